/* core/mstc_pkg.sv */
// Purpose: Shared constants and types for the microstep translator and chopper.
// Assumes: 25 MHz core clock.
// Notes:   Timing counts are derived from times written in their own units.
package mstc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ       = 25;
  localparam int TBLANK_NS     = 1000;
  localparam int BLANK_CYC     = ((TBLANK_NS * CLK_MHZ + 999) / 1000 < 1) ? 1 :
                                 (TBLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int TOFF_DEF_US   = 30;
  localparam int TOFF_DEF_CYC  = TOFF_DEF_US * CLK_MHZ;
  localparam int OFFTIME_RESISTOR_PIN_DIV      = 825;
  localparam int FAST_NUM      = 5;
  localparam int FAST_SHIFT    = 4;
  localparam int OFF_W         = 16;
  localparam int BLANK_W       = 8;

  // ****************************************************************
  // Translator
  // ****************************************************************
  localparam int IDX_W         = 6;
  localparam int LEVEL_W       = 8;
  localparam int TAB_AW        = 5;
  localparam int TAB_DEPTH     = 17;
  localparam int QTR_STEPS     = 16;
  localparam logic [IDX_W-1:0]   IDX_HOME   = 6'h08;
  localparam logic [LEVEL_W-1:0] HOME_LEVEL = 8'hb4;
  localparam logic [1:0]         DECAY_HOME = 2'h3;
  localparam logic               DECAY_MIXED = 1'b1;
  localparam logic               DECAY_SLOW  = 1'b0;

  // Resolution code is {resolution_sel_hi, resolution_sel_lo}.
  localparam logic [1:0] RES_FULL      = 2'h0;
  localparam logic [1:0] RES_HALF      = 2'h1;
  localparam logic [1:0] RES_QUARTER   = 2'h2;
  localparam logic [1:0] RES_SIXTEENTH = 2'h3;
  localparam logic [IDX_W-1:0] INC_FULL      = 6'h10;
  localparam logic [IDX_W-1:0] INC_HALF      = 6'h08;
  localparam logic [IDX_W-1:0] INC_QUARTER   = 6'h04;
  localparam logic [IDX_W-1:0] INC_SIXTEENTH = 6'h01;

  // Quarter sine of the phase current, 255 standing for full trip current.
  localparam logic [LEVEL_W-1:0] SINE_TAB [TAB_DEPTH] = '{
    8'h00, 8'h19, 8'h32, 8'h4a, 8'h62, 8'h78, 8'h8e, 8'ha2, 8'hb4,
    8'hc5, 8'hd4, 8'he1, 8'hec, 8'hf4, 8'hfa, 8'hfe, 8'hff};

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int OFFR_W = 20;
  localparam logic [7:0]        REG_CTRL    = 8'h00;
  localparam logic [7:0]        REG_OFFR    = 8'h04;
  localparam logic [7:0]        REG_STATUS  = 8'h08;
  localparam logic [7:0]        REG_LEVELS  = 8'h0c;
  localparam int                CTRL_TIED   = 0;
  localparam logic              CTRL_RESET  = 1'b1;
  localparam logic [OFFR_W-1:0] OFFR_RESET  = 20'h061a8;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic src_a;
    logic src_b;
    logic snk_a;
    logic snk_b;
  } mstc_sw_t;

  typedef struct packed {
    logic             fault;
    logic             asleep;
    logic [1:0]       neg;
    logic [1:0]       decay;
    logic             dir;
    logic [1:0]       res;
    logic [IDX_W-1:0] idx;
  } mstc_status_t;

  typedef enum logic [1:0] {CH_ON, CH_FAST, CH_SLOW} mstc_chop_state_t;

endpackage

/* core/mstc_level_rom.sv */
// Purpose: Two-port registered lookup of the quarter-wave phase current level.
// Assumes: Addresses stay within the table depth.
// Notes:   Read data appear one enabled clock after the address.
`timescale 1ns/1ns
module mstc_level_rom
  import mstc_pkg::*;
(
  // Clock
  input  wire logic               i_clk,
  input  wire logic               i_ce,
  // Read ports
  input  wire logic [TAB_AW-1:0]  i_addr_a,
  input  wire logic [TAB_AW-1:0]  i_addr_b,
  output logic      [LEVEL_W-1:0] o_data_a,
  output logic      [LEVEL_W-1:0] o_data_b
);

  always_ff @(posedge i_clk) begin
    if (i_ce) begin
      o_data_a <= SINE_TAB[i_addr_a];
      o_data_b <= SINE_TAB[i_addr_b];
    end
  end

endmodule

/* core/mstc_bridge_chop.sv */
// Purpose: Fixed off-time current chopper for one full bridge.
// Assumes: i_trip is the bridge's sense comparator, synchronous to i_clk.
// Notes:   The decay mode is taken at the moment of the trip.
`timescale 1ns/1ns
module mstc_bridge_chop
  import mstc_pkg::*;
(
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_ce,
  // Control
  input  wire logic             i_run,
  input  wire logic             i_mixed,
  input  wire logic             i_neg,
  input  wire logic             i_trip,
  input  wire logic [OFF_W-1:0] i_off_cycles,
  // Switches
  output mstc_sw_t              o_sw
);

  mstc_chop_state_t   state;
  logic [OFF_W-1:0]   cnt;
  logic [BLANK_W-1:0] blank;
  logic [OFF_W-1:0]   slow_part;
  mstc_sw_t           diag;
  mstc_sw_t           sinks;

  // ****************************************************************
  // Switch patterns
  // ****************************************************************
  always_comb begin
    diag  = i_neg ? mstc_sw_t'{src_a: 1'b0, src_b: 1'b1, snk_a: 1'b1, snk_b: 1'b0}
                  : mstc_sw_t'{src_a: 1'b1, src_b: 1'b0, snk_a: 1'b0, snk_b: 1'b1};
    sinks = mstc_sw_t'{src_a: 1'b0, src_b: 1'b0, snk_a: 1'b1, snk_b: 1'b1};
    slow_part = i_off_cycles - OFF_W'((32'(i_off_cycles) * FAST_NUM) >> FAST_SHIFT);
  end

  // ****************************************************************
  // Chopper state
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state <= CH_ON;
      cnt   <= '0;
      blank <= BLANK_W'(BLANK_CYC);
      o_sw  <= '0;
    end else if (i_ce) begin
      if (!i_run) begin
        state <= CH_ON;
        blank <= BLANK_W'(BLANK_CYC);
        o_sw  <= '0;
      end else begin
        case (state)
          CH_ON: begin
            // The comparator is ignored while switching transients settle.
            if (blank != '0) begin
              blank <= blank - 1'b1; // [R16]
              o_sw  <= diag; // [R11]
            end else if (i_trip) begin
              cnt   <= i_off_cycles; // [R14]
              blank <= BLANK_W'(BLANK_CYC); // [R16]
              if (i_mixed) begin
                state <= CH_FAST;
                o_sw  <= '0; // [R12]
              end else begin
                state <= CH_SLOW;
                o_sw  <= sinks; // [R12]
              end
            end else begin
              o_sw <= diag; // [R11]
            end
          end
          CH_FAST: begin
            cnt <= cnt - 1'b1;
            if (cnt <= slow_part) begin
              state <= CH_SLOW; // [R17]
              o_sw  <= sinks;
            end
          end
          default: begin
            cnt <= cnt - 1'b1;
            if (cnt <= OFF_W'(1)) begin
              state <= CH_ON;
              blank <= BLANK_W'(BLANK_CYC);
              o_sw  <= diag;
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_blank_hold;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && i_run && state == CH_ON && blank != '0) |=> state == CH_ON;
  endproperty
  a_blank_hold: assert property (p_blank_hold) else $error("trip taken inside blank"); // [R16]

endmodule

/* core/mstc_translator_chopper.sv */
// Purpose: Step translator with per-bridge fixed off-time chopping and APB status.
// Assumes: All pins synchronous to i_clk; APB slave with one wait state.
// Notes:   Level codes drive the phase DACs; 255 is full trip current.
// Summary of operation
// [R1] Power-on or reset loads Home levels and polarities, both bridges Mixed decay.
// [R2] Each rising advance pulse moves the translator one increment.
// [R3] Each increment steps the DACs along the fixed sequence at the chosen resolution.
// [R4] A bridge whose new level is lower goes to Mixed decay.
// [R5] A bridge whose new level is higher or equal goes to Slow decay.
// [R6] Reset pin low holds Home, switches off, and ignores steps.
// [R7] Resolution selects are taken only at an advance pulse edge.
// [R8] Selects low/low full, high/low half, low/high quarter, high/high sixteenth.
// [R9] Rotation sense low is clockwise, high counterclockwise.
// [R10] Rotation sense changes act only at the next advance pulse edge.
// [R11] On phase drives one diagonal pair until the comparator trips.
// [R12] Trip turns off sources in Slow decay, sources and sinks in Mixed.
// [R13] Trip threshold is the step's share of the peak trip current.
// [R14] A one-shot times the off interval, resistance over 825 in microseconds.
// [R15] Off interval pin tied high gives 30 microseconds.
// [R16] Comparators are ignored about 1 microsecond after each switching.
// [R17] Mixed decay is fast for 31.25 percent of off time, then slow.
// [R18] A low side gate supply fault disables all switches.
// [R19] Over-temperature or pump undervoltage disables switches until cleared.
// [R20] Supply lockout disables switches and returns the translator Home.
// [R21] Output disable high turns all switches off.
// [R22] Translator keeps working whatever the output disable state.
// [R23] Sleep low stops switches, regulator and pump; waking goes Home.
// [R24] The controller waits 1 ms after waking before the first step.
// [R25] Home is the 45 degree point; the table runs counterclockwise.
// [R26] A 64-entry index moves by 16, 8, 4 or 1, wrapping.
// [R27] Index rises one way, falls the other; levels and polarity come from it.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns
module mstc_translator_chopper
  import mstc_pkg::*;
(
  // Clock and reset
  input  wire logic                    i_clk,
  input  wire logic                    i_resetn,
  input  wire logic                    i_ce,
  // APB slave
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [31:0]             i_paddr,
  input  wire logic [31:0]             i_pwdata,
  output logic      [31:0]             o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  // Translator pins
  input  wire logic                    i_advance_pulse,
  input  wire logic                    i_rotation_sense,
  input  wire logic                    i_resolution_sel_lo,
  input  wire logic                    i_resolution_sel_hi,
  input  wire logic                    i_translator_resetn,
  input  wire logic                    i_output_disable,
  input  wire logic                    i_sleepn,
  // Protection
  input  wire logic                    i_gate_supply_fault,
  input  wire logic                    i_overtemp,
  input  wire logic                    i_pump_undervolt,
  input  wire logic                    i_supply_lockout,
  // Bridges
  input  wire logic [1:0]              i_sense_trip,
  output mstc_sw_t  [1:0]              o_sw,
  output logic      [1:0][LEVEL_W-1:0] o_dac_level,
  output logic      [1:0]              o_decay_mixed,
  output logic                         o_pump_en
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                    step_prev;
  logic                    step_rise;
  logic                    home_req;
  logic                    fault;
  logic                    run_in;
  logic                    run;
  logic [IDX_W-1:0]        idx;
  logic [IDX_W-1:0]        inc;
  logic [1:0]              res_used;
  logic                    dir_used;
  logic                    pend1;
  logic                    pend2;
  logic [1:0]              neg;
  logic [1:0]              next_neg;
  logic [1:0][TAB_AW-1:0]  tab_addr;
  logic [1:0][LEVEL_W-1:0] tab_q;
  logic                    ctrl_tied;
  logic [OFFR_W-1:0]       offr;
  logic [OFF_W-1:0]        off_cycles;
  logic [OFF_W-1:0]        next_off;
  logic [IDX_W-3:0]        rem;
  mstc_status_t            status;
  logic                    acc;

  assign step_rise = i_advance_pulse && !step_prev;
  assign fault     = i_gate_supply_fault || i_overtemp || i_pump_undervolt; // [R18] [R19]
  assign home_req  = !i_translator_resetn || i_supply_lockout || !i_sleepn; // [R6] [R20] [R23]
  assign run_in    = i_sleepn && i_translator_resetn && !i_output_disable
                     && !fault && !i_supply_lockout; // [R21]

  // ****************************************************************
  // Translator index
  // ****************************************************************
  always_comb begin
    case ({i_resolution_sel_hi, i_resolution_sel_lo}) // [R8]
      RES_FULL:    inc = INC_FULL; // [R26]
      RES_HALF:    inc = INC_HALF;
      RES_QUARTER: inc = INC_QUARTER;
      default:     inc = INC_SIXTEENTH;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      step_prev <= 1'b0;
      idx       <= IDX_HOME; // [R1] [R25]
      res_used  <= RES_FULL;
      dir_used  <= 1'b0;
      pend1     <= 1'b0;
    end else if (i_ce) begin
      step_prev <= i_advance_pulse;
      pend1     <= 1'b0;
      if (home_req) begin
        idx <= IDX_HOME; // [R6] [R20] [R23]
      end else if (step_rise) begin // [R22]
        // Selects and sense are looked at only here, so mid-step changes wait.
        res_used <= {i_resolution_sel_hi, i_resolution_sel_lo}; // [R7]
        dir_used <= i_rotation_sense; // [R10]
        pend1    <= 1'b1; // [R2]
        if (i_rotation_sense) begin
          idx <= idx + inc; // [R9] [R27] [R3]
        end else begin
          idx <= idx - inc; // [R9] [R27]
        end
      end
    end
  end

  // ****************************************************************
  // Phase level lookup
  // ****************************************************************
  // Phase 1 follows the cosine and phase 2 the sine of the index angle.
  always_comb begin
    rem         = idx[IDX_W-3:0];
    tab_addr[0] = idx[IDX_W-2] ? TAB_AW'(rem) : TAB_AW'(QTR_STEPS - 32'(rem)); // [R27]
    tab_addr[1] = idx[IDX_W-2] ? TAB_AW'(QTR_STEPS - 32'(rem)) : TAB_AW'(rem);
    next_neg[0] = idx[IDX_W-1] ^ idx[IDX_W-2];
    next_neg[1] = idx[IDX_W-1];
  end

  mstc_level_rom u_rom (
    .i_clk    (i_clk),
    .i_ce     (i_ce),
    .i_addr_a (tab_addr[0]),
    .i_addr_b (tab_addr[1]),
    .o_data_a (tab_q[0]),
    .o_data_b (tab_q[1])
  );

  // ****************************************************************
  // DAC levels, polarity and decay selection
  // ****************************************************************
  // The level code is the step's share of peak trip current; the analog
  // divider by eight of the reference lives outside this block.
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      pend2         <= 1'b0;
      o_dac_level   <= {HOME_LEVEL, HOME_LEVEL}; // [R1]
      neg           <= 2'h0;
      o_decay_mixed <= DECAY_HOME; // [R1]
    end else if (i_ce) begin
      pend2 <= pend1 && !home_req;
      if (home_req) begin
        o_dac_level   <= {HOME_LEVEL, HOME_LEVEL}; // [R6] [R20]
        neg           <= 2'h0;
        o_decay_mixed <= DECAY_HOME; // [R1]
      end else if (pend2) begin
        neg <= next_neg; // [R2]
        for (int b = 0; b < 2; b++) begin
          o_dac_level[b] <= tab_q[b]; // [R3] [R13]
          if (tab_q[b] < o_dac_level[b]) begin
            o_decay_mixed[b] <= DECAY_MIXED; // [R4]
          end else begin
            o_decay_mixed[b] <= DECAY_SLOW; // [R5]
          end
        end
      end
    end
  end

  // ****************************************************************
  // Output permission and off-time
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      run        <= 1'b0;
      o_pump_en  <= 1'b0;
      off_cycles <= OFF_W'(TOFF_DEF_CYC);
    end else if (i_ce) begin
      run        <= run_in;
      o_pump_en  <= i_sleepn; // [R23]
      off_cycles <= next_off;
    end
  end

  always_comb begin
    if (ctrl_tied) begin
      next_off = OFF_W'(TOFF_DEF_CYC); // [R15]
    end else begin
      next_off = OFF_W'((32'(offr) * CLK_MHZ) / OFFTIME_RESISTOR_PIN_DIV); // [R14]
      if (next_off == '0) begin
        next_off = OFF_W'(1);
      end
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_bridge
    mstc_bridge_chop u_chop (
      .i_clk        (i_clk),
      .i_resetn     (i_resetn),
      .i_ce         (i_ce),
      .i_run        (run),
      .i_mixed      (o_decay_mixed[g]),
      .i_neg        (neg[g]),
      .i_trip       (i_sense_trip[g]),
      .i_off_cycles (off_cycles),
      .o_sw         (o_sw[g])
    );
  end

  // ****************************************************************
  // APB registers
  // ****************************************************************
  always_comb begin
    status.fault  = fault || i_supply_lockout;
    status.asleep = !i_sleepn;
    status.neg    = neg;
    status.decay  = o_decay_mixed;
    status.dir    = dir_used;
    status.res    = res_used;
    status.idx    = idx;
  end

  // One wait state keeps every bus output registered.
  assign acc = i_psel && i_penable && !o_pready;

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      o_pready  <= 1'b0;
      o_prdata  <= '0;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      o_pready  <= acc;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
      if (acc) begin
        if (i_paddr == 32'(REG_CTRL)) begin
          o_prdata <= 32'(ctrl_tied);
        end else if (i_paddr == 32'(REG_OFFR)) begin
          o_prdata <= 32'(offr);
        end else if (i_paddr == 32'(REG_STATUS)) begin
          o_prdata <= 32'(status);
        end else if (i_paddr == 32'(REG_LEVELS)) begin
          o_prdata <= 32'(o_dac_level);
        end else begin
          o_pslverr <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      ctrl_tied <= CTRL_RESET;
      offr      <= OFFR_RESET;
    end else if (i_ce && i_psel && i_penable && o_pready && i_pwrite) begin
      if (i_paddr == 32'(REG_CTRL)) begin
        ctrl_tied <= i_pwdata[CTRL_TIED];
      end else if (i_paddr == 32'(REG_OFFR)) begin
        offr <= i_pwdata[OFFR_W-1:0];
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_home_hold;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && home_req) |=> (idx == IDX_HOME && o_decay_mixed == DECAY_HOME);
  endproperty
  a_home_hold: assert property (p_home_hold) else $error("not at Home under reset"); // [R6]

  property p_ccw_sixteenth;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && step_rise && !home_req && i_resolution_sel_lo && i_resolution_sel_hi
     && i_rotation_sense) |=> idx == $past(idx) + 6'h01;
  endproperty
  a_ccw_sixteenth: assert property (p_ccw_sixteenth) else $error("bad sixteenth step"); // [R26]

  property p_cw_full;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && step_rise && !home_req && !i_resolution_sel_lo && !i_resolution_sel_hi
     && !i_rotation_sense) |=> idx == $past(idx) - 6'h10;
  endproperty
  a_cw_full: assert property (p_cw_full) else $error("bad full step clockwise"); // [R9]

  property p_no_edge_hold;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && !step_rise && !home_req) |=> ($stable(idx) && $stable(res_used) && $stable(dir_used));
  endproperty
  a_no_edge_hold: assert property (p_no_edge_hold) else $error("moved without edge"); // [R7]

  property p_decay_mixed;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && pend2 && !home_req && tab_q[0] < o_dac_level[0]) |=> o_decay_mixed[0];
  endproperty
  a_decay_mixed: assert property (p_decay_mixed) else $error("falling level not Mixed"); // [R4]

  property p_decay_slow;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && pend2 && !home_req && tab_q[1] >= o_dac_level[1]) |=> !o_decay_mixed[1];
  endproperty
  a_decay_slow: assert property (p_decay_slow) else $error("rising level not Slow"); // [R5]

  property p_switches_off;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && !run_in) [*2] |=> o_sw == '0;
  endproperty
  a_switches_off: assert property (p_switches_off) else $error("switch on while disabled"); // [R21]

  property p_pump_sleep;
    @(posedge i_clk) disable iff (!i_resetn)
    (i_ce && !i_sleepn) |=> !o_pump_en;
  endproperty
  a_pump_sleep: assert property (p_pump_sleep) else $error("pump on in sleep"); // [R23]

  c_step_half: cover property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && step_rise && !home_req && i_resolution_sel_lo && !i_resolution_sel_hi);
  c_mixed_trip: cover property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && run && o_decay_mixed[0] && i_sense_trip[0]);
  c_step_disabled: cover property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && step_rise && !home_req && i_output_disable);

endmodule

/* tb/mstc_step_host.sv */
// Purpose: Step pulse source standing in for the controller.
// Assumes: i_go is a one-cycle request from the bench.
// Notes:   Requests wait while the pump settles after sleep.
`timescale 1ns/1ns
module mstc_step_host #(
  parameter int WAKE_CYC = 25000
) (
  input  wire logic i_clk,
  input  wire logic i_sleepn,
  input  wire logic i_go,
  output logic      o_pulse,
  output logic      o_busy
);
  int wait_cnt;
  int ph;
  bit pend;
  always_ff @(posedge i_clk) begin
    wait_cnt <= !i_sleepn ? WAKE_CYC : (wait_cnt > 0 ? wait_cnt - 1 : 0);
    pend     <= i_go | (pend & ph == 0 & (wait_cnt != 0 | !i_sleepn));
    ph       <= ph > 0 ? ph - 1 : (pend && wait_cnt == 0 && i_sleepn ? 4 : 0);
  end
  // Two cycles high and at least three low keep steps apart as the pipeline needs.
  assign o_pulse = ph > 2;
  assign o_busy  = pend | ph != 0;
endmodule

/* tb/mstc_translator_chopper_tb_top.sv */
// Purpose: Self-checking bench for the translator and chopper.
// Assumes: Comparators stay idle unless a trip is being tested.
// Notes:   Expected levels are rebuilt from the quarter sine table.
`timescale 1ns/1ns
module mstc_translator_chopper_tb_top;
  import mstc_pkg::*;
  logic        i_clk = 0, i_resetn = 0, i_ce = 1, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic        i_rotation_sense = 0, i_resolution_sel_lo = 0, i_resolution_sel_hi = 0;
  logic        i_translator_resetn = 1, i_sleepn = 1, i_output_disable = 0, i_overtemp = 0;
  logic        i_gate_supply_fault = 0, i_pump_undervolt = 0, i_supply_lockout = 0, go = 0;
  logic        i_advance_pulse, o_pready, o_pslverr, o_pump_en, busy, er;
  logic [1:0]  i_sense_trip = 0, o_decay_mixed;
  logic [31:0] i_paddr = 0, i_pwdata = 0, o_prdata, rd, seed = 32'h8940f03e;
  logic [15:0] o_dac_level;
  logic [7:0]  o_sw;
  logic [5:0]  idx = IDX_HOME, prv;
  int          n_fail = 0, tests_run = 0, cyc = 0, k;
  localparam logic [5:0] INC [4] = '{6'h10, 6'h08, 6'h04, 6'h01};

  mstc_translator_chopper mstc_translator_chopper_inst (.*);
  mstc_step_host mstc_step_host_inst (.i_clk(i_clk), .i_sleepn(i_sleepn), .i_go(go),
                                      .o_pulse(i_advance_pulse), .o_busy(busy));

  initial forever #20 i_clk = ~i_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] lvl(input logic [5:0] i);
    return (i[4:0] <= 5'd16) ? SINE_TAB[i[4:0]] : SINE_TAB[6'd32 - i[4:0]];
  endfunction
  // Phase 2 follows the sine of the index, phase 1 the cosine.
  function automatic logic [15:0] lv(input logic [5:0] i);
    return {lvl(i), lvl(i + 6'd16)};
  endfunction

  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    i_psel <= 1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1;
    do @(posedge i_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
    @(posedge i_clk);
  endtask
  task automatic step();
    go <= 1;
    @(posedge i_clk);
    go <= 0;
    do @(posedge i_clk); while (i_advance_pulse !== 1'b1);
    // Pins flip just after the taken edge; that step must still use the old ones.
    i_rotation_sense <= ~i_rotation_sense;
    {i_resolution_sel_hi, i_resolution_sel_lo} <= ~{i_resolution_sel_hi, i_resolution_sel_lo};
    while (busy !== 1'b0) @(posedge i_clk);
    @(posedge i_clk);
  endtask
  // Settings on the pins are read before the step, as the device samples them at its edge.
  task automatic adv();
    prv = idx;
    idx = i_rotation_sense ? idx + INC[{i_resolution_sel_hi, i_resolution_sel_lo}]
                           : idx - INC[{i_resolution_sel_hi, i_resolution_sel_lo}];
    step();
    chk("level", lv(idx), o_dac_level);
    chk("decay", {lvl(idx) < lvl(prv), lvl(idx + 6'd16) < lvl(prv + 6'd16)},
        o_decay_mixed);
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    repeat (3) @(posedge i_clk);
    i_resetn <= 1;
    @(posedge i_clk);
    chk("home", lv(IDX_HOME), o_dac_level);
    chk("mixed", DECAY_HOME, o_decay_mixed);
    apb(0, REG_STATUS, 0);
    chk("status", IDX_HOME, rd[5:0]);
    apb(1, REG_OFFR, 32'h3039);
    apb(0, REG_OFFR, 0);
    chk("offr", 32'h3039, rd);
    apb(0, 32'h10, 0);
    chk("slverr", 1, er);
    for (k = 0; k < 120; k++) begin
      seed = lfsr(seed);
      i_rotation_sense <= seed[0];
      {i_resolution_sel_hi, i_resolution_sel_lo} <= (k < 4) ? k[1:0] : seed[2:1];
      i_output_disable <= seed[3];
      repeat (4) @(posedge i_clk);
      chk("idle", lv(idx), o_dac_level);
      adv();
      if (seed[3]) chk("disabled", 0, o_sw);
      else chk("diag", {((idx >= 6'd32) ? 4'h6 : 4'h9),
                        ((idx >= 6'd16 && idx < 6'd48) ? 4'h6 : 4'h9)}, o_sw);
    end
    i_output_disable <= 0;
    i_translator_resetn <= 0;
    repeat (4) @(posedge i_clk);
    chk("rst", 0, o_sw);
    step();
    chk("rst", lv(IDX_HOME), o_dac_level);
    i_translator_resetn <= 1;
    idx = IDX_HOME;
    repeat (40) @(posedge i_clk);
    chk("on", 8'h99, o_sw);
    i_sense_trip <= 2'h1;
    @(posedge i_clk);
    i_sense_trip <= 2'h0;
    @(posedge i_clk);
    chk("trip", 8'h90, o_sw);
    repeat (200) @(posedge i_clk);
    chk("fast", 8'h90, o_sw);
    repeat (60) @(posedge i_clk);
    chk("slow", 8'h93, o_sw);
    repeat (520) @(posedge i_clk);
    chk("again", 8'h99, o_sw);
    // Resistor setting 12345 ohms gives 374 off cycles once the pin is not tied high.
    apb(1, REG_CTRL, 0);
    i_sense_trip <= 2'h1;
    @(posedge i_clk);
    i_sense_trip <= 2'h0;
    repeat (371) @(posedge i_clk);
    chk("short", 8'h93, o_sw);
    repeat (10) @(posedge i_clk);
    chk("resume", 8'h99, o_sw);
    adv();
    for (k = 0; k < 4; k++) begin
      {i_gate_supply_fault, i_overtemp, i_pump_undervolt, i_supply_lockout} <= 4'h8 >> k;
      repeat (3) @(posedge i_clk);
      chk("fault", 0, o_sw);
    end
    i_supply_lockout <= 0;
    repeat (3) @(posedge i_clk);
    chk("lockout", lv(IDX_HOME), o_dac_level);
    idx = IDX_HOME;
    adv();
    i_sleepn <= 0;
    repeat (3) @(posedge i_clk);
    chk("sleep", 0, {o_pump_en, o_sw});
    i_sleepn <= 1;
    idx = IDX_HOME;
    adv();
    chk("pump", 1, o_pump_en);
    end_of_test();
  end
endmodule
